/* rtl/fpec_top.sv */
// fpec_top: flash program / erase sequencer with unlock protection
// assumes a 20 MHz system clock, avalon-mm register port and a flash array port
//
// How it works
// (RULE_01) key register is write-only, reads zero
// (RULE_02) 55h then AAh required before start
// (RULE_03) start bit set-only, hardware clears
// (RULE_04) processor stalled while operation runs
// (RULE_05) allow bit zero inhibits every operation
// (RULE_06) error flag on improper start attempt
// (RULE_07) erase bit picks erase versus program
// (RULE_08) codes 1,3 program; code 2 block erase
// (RULE_09) code F bulk erase, serial mode only
// (RULE_10) undefined codes perform nothing
// (RULE_11) unused control bits read zero
// (RULE_12) control bits cleared only by power-on
// (RULE_13) block erase clears aligned 512 words
// (RULE_14) row program writes 64 latched words
// (RULE_15) software configures, unlocks, then starts
// (RULE_16) software follows start with two nops
// (RULE_17) table writes stay in latches
// (RULE_18) rows and blocks aligned to size
// (RULE_19) unlock breaks on any intervening write
`timescale 1ns/1ns
module fpec_top
  import fpec_pkg::*;
#(
  parameter int ROW_WORDS   = FPEC_ROW_WORDS,
  parameter int BLOCK_WORDS = FPEC_BLOCK_WORDS
) (
  // clock and power-on reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // avalon-mm register slave
  input  wire logic [3:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  output logic                          irq,
  // table write port into the holding latches
  input  wire logic                     tbl_wr,
  input  wire logic [7:0]               table_page_reg,
  input  wire logic [15:0]              tbl_offset,
  input  wire logic [FPEC_DATA_W-1:0]   tbl_data,
  // mode strap for serial programming
  input  wire logic                     serial_prog_mode,
  // processor stall
  output logic                          cpu_stall,
  // flash array
  output logic                          fl_prog,
  output logic                          fl_erase,
  output logic [FPEC_ADDR_W-1:0]        fl_addr,
  output logic [FPEC_DATA_W-1:0]        fl_wdata,
  input  wire logic                     fl_busy
);
  import fpec_pkg::*;

  localparam int RW = $clog2(ROW_WORDS);
  localparam int BW = $clog2(BLOCK_WORDS);
  localparam logic [FPEC_ADDR_W-1:0] CNT_ONE = 23'h000001;

  ////////////////////////////////////////////////////////////////////////////
  // control register and unlock state

  logic [15:0]       ctrl_r;
  logic [1:0]        unlock_r;
  logic [1:0]        sts_r;
  logic [1:0]        mask_r;
  fpec_state_t       state_r;
  logic [FPEC_ADDR_W-1:0] base_r;
  logic [FPEC_ADDR_W-1:0] cnt_r;
  logic [FPEC_ADDR_W-1:0] len_r;
  logic [1:0]        step_r;
  logic              op_erase_r;
  logic              op_bulk_r;
  logic              done_pulse;
  logic              err_pulse;
  logic              ser_m_r;
  logic              ser_r;
  logic              busy_m_r;
  logic              busy_r;
  logic              rd_ack_r;

  logic [3:0]  op_sel;
  logic        erase_sel;
  logic        wr_ctrl;
  logic        wr_key;
  logic        key_first;
  logic        key_second;
  logic        start_req;
  logic        op_valid;
  logic        go;

  assign op_sel    = ctrl_r[3:0];
  assign erase_sel = ctrl_r[FPEC_BIT_ERASE];
  assign wr_ctrl   = avs_write && avs_address == FPEC_OFS_CONTROL && avs_byteenable[1];
  assign wr_key    = avs_write && avs_address == FPEC_OFS_KEY && avs_byteenable[0];
  assign key_first  = wr_key && avs_writedata[7:0] == FPEC_KEY_FIRST;
  assign key_second = wr_key && avs_writedata[7:0] == FPEC_KEY_SECOND;
  assign start_req = wr_ctrl && avs_writedata[FPEC_BIT_START];

  // legal code and erase-bit pairing
  function automatic logic op_legal(input logic [3:0] op, input logic er, input logic ser);
    unique case (op)
      FPEC_OP_ROW,
      FPEC_OP_WORD:  op_legal = !er;
      FPEC_OP_BLOCK: op_legal = er;
      FPEC_OP_BULK:  op_legal = er && ser;
      default:       op_legal = 1'b0;
    endcase
  endfunction

  assign op_valid = op_legal(op_sel, erase_sel, ser_r); // RULE_07 RULE_08 RULE_09 RULE_10
  // start only with full unlock, allow bit, idle machine
  assign go = start_req && unlock_r == 2'd2 && ctrl_r[FPEC_BIT_ALLOW]
              && op_valid && state_r == FPEC_IDLE; // RULE_02 RULE_05

  // synchronise pins from outside the clock domain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_m_r  <= 1'b0;
      ser_r    <= 1'b0;
      busy_m_r <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      ser_m_r  <= serial_prog_mode;
      ser_r    <= ser_m_r;
      busy_m_r <= fl_busy;
      busy_r   <= busy_m_r;
    end
  end

  // unlock tracker: any other register write breaks the chain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_r <= 2'd0;
    end else if (avs_write && !avs_waitrequest) begin
      if (key_first) begin
        unlock_r <= 2'd1; // RULE_02
      end else if (key_second && unlock_r == 2'd1) begin
        unlock_r <= 2'd2; // RULE_02
      end else begin
        unlock_r <= 2'd0; // RULE_19
      end
    end
  end

  // reset_n is the power-on reset; no other reset reaches these bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= FPEC_CTRL_RESET; // RULE_12
    end else begin
      if (wr_ctrl && !avs_waitrequest) begin
        ctrl_r[FPEC_BIT_ALLOW] <= avs_writedata[FPEC_BIT_ALLOW];
        ctrl_r[FPEC_BIT_ERASE] <= avs_writedata[FPEC_BIT_ERASE];
        ctrl_r[3:0]            <= avs_writedata[3:0];
        // a write of zero never clears the start bit
        if (go) begin
          ctrl_r[FPEC_BIT_START] <= 1'b1; // RULE_03
        end
      end
      // error is set on a refused start, cleared on a good one
      // only a taken write counts, a start held through a wait state sets nothing
      if (err_pulse) begin
        ctrl_r[FPEC_BIT_ERR] <= 1'b1; // RULE_06
      end else if (go) begin
        ctrl_r[FPEC_BIT_ERR] <= 1'b0;
      end
      if (done_pulse) begin
        ctrl_r[FPEC_BIT_START] <= 1'b0; // RULE_03
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // aligned start address of the row or block
  function automatic logic [FPEC_ADDR_W-1:0] align(input logic [FPEC_ADDR_W-1:0] a,
                                                   input int words);
    align = a & ~FPEC_ADDR_W'(words - 1);
  endfunction

  logic [FPEC_ADDR_W-1:0] tbl_addr;
  logic [RW-1:0]          lat_rd;
  logic [FPEC_DATA_W-1:0] lat_q;
  logic                   step_end;

  assign tbl_addr = {table_page_reg[6:0], tbl_offset[15:1], 1'b0} >> 1;
  assign step_end = step_r == 2'(FPEC_STEP_CYC - 1) && !busy_r;

  fpec_latch_mem #(
    .WORDS (ROW_WORDS),
    .DW    (FPEC_DATA_W)
  ) u_latch (
    .clk     (clk),
    .wr_en   (tbl_wr && state_r == FPEC_IDLE),
    .wr_addr (tbl_addr[RW-1:0]),
    .wr_data (tbl_data),
    .rd_addr (lat_rd),
    .rd_data (lat_q)
  ); // RULE_17

  // look one word ahead on a step end so the registered latch output is ready
  assign lat_rd = RW'(step_end ? cnt_r + CNT_ONE : cnt_r);

  // remember the last table address as the target
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_r <= '0;
    end else if (tbl_wr && state_r == FPEC_IDLE) begin
      base_r <= tbl_addr;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= FPEC_IDLE;
      cnt_r      <= '0;
      len_r      <= '0;
      step_r     <= '0;
      op_erase_r <= 1'b0;
      op_bulk_r  <= 1'b0;
      fl_addr    <= '0;
    end else begin
      unique case (state_r)
        FPEC_IDLE: begin
          step_r <= '0;
          cnt_r  <= '0;
          if (go) begin
            state_r    <= FPEC_RUN;
            op_erase_r <= erase_sel;
            op_bulk_r  <= op_sel == FPEC_OP_BULK; // RULE_09
            unique case (op_sel)
              FPEC_OP_ROW: begin
                len_r   <= FPEC_ADDR_W'(ROW_WORDS); // RULE_14
                fl_addr <= align(base_r, ROW_WORDS); // RULE_18
              end
              FPEC_OP_BLOCK: begin
                len_r   <= FPEC_ADDR_W'(BLOCK_WORDS); // RULE_13
                fl_addr <= align(base_r, BLOCK_WORDS); // RULE_18
              end
              FPEC_OP_WORD: begin
                len_r   <= CNT_ONE;
                fl_addr <= base_r;
              end
              default: begin
                // bulk: one array-wide command
                len_r   <= CNT_ONE;
                fl_addr <= '0;
              end
            endcase
          end
        end
        FPEC_RUN: begin
          // park on the last step while busy, a wrap would strobe the word again
          if (step_r != 2'(FPEC_STEP_CYC - 1)) begin
            step_r <= step_r + 2'd1;
          end
          if (step_end) begin
            step_r  <= '0;
            cnt_r   <= cnt_r + CNT_ONE;
            fl_addr <= fl_addr + CNT_ONE;
            if (cnt_r + CNT_ONE == len_r) begin
              state_r <= FPEC_DONE;
            end
          end
        end
        FPEC_DONE: begin
          state_r <= FPEC_IDLE;
        end
        default: begin
          state_r <= FPEC_IDLE;
        end
      endcase
    end
  end

  assign done_pulse = state_r == FPEC_DONE;
  assign err_pulse  = start_req && !go && !avs_waitrequest;

  // flash strobes: program and block erase pulse once per word, bulk erase pulses once at address zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fl_prog  <= 1'b0;
      fl_erase <= 1'b0;
      fl_wdata <= '0;
    end else begin
      fl_prog  <= state_r == FPEC_RUN && !op_erase_r && step_r == '0;
      fl_erase <= state_r == FPEC_RUN && op_erase_r && step_r == '0 && !op_bulk_r;
      fl_wdata <= lat_q;
      if (state_r == FPEC_RUN && op_bulk_r && step_r == '0) begin
        fl_erase <= 1'b1;
      end
    end
  end

  // stall the processor while an operation runs
  assign cpu_stall = state_r != FPEC_IDLE; // RULE_04

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sts_r <= '0;
    end else begin
      // set wins over a clear in the same cycle
      if (avs_write && !avs_waitrequest && avs_address == FPEC_OFS_STATUS
          && avs_byteenable[0]) begin
        sts_r <= sts_r & ~avs_writedata[1:0];
      end
      if (done_pulse) begin
        sts_r[FPEC_IRQ_DONE] <= 1'b1;
      end
      if (err_pulse) begin
        sts_r[FPEC_IRQ_ERR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= '0;
    end else if (avs_write && !avs_waitrequest && avs_address == FPEC_OFS_MASK
                 && avs_byteenable[0]) begin
      mask_r <= avs_writedata[1:0];
    end
  end

  assign irq = |(sts_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // register read

  // reads get one wait state so the registered read data stand at the taking edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= avs_read && !rd_ack_r && state_r == FPEC_IDLE;
    end
  end

  // bus accesses wait while the sequencer runs, the processor is stalled anyway
  assign avs_waitrequest = (avs_write && state_r != FPEC_IDLE)
                           || (avs_read && (state_r != FPEC_IDLE || !rd_ack_r)); // RULE_04

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= '0;
    end else if (avs_read) begin
      unique case (avs_address)
        FPEC_OFS_CONTROL: avs_readdata <= {16'h0000, ctrl_r & FPEC_CTRL_WMASK
                                           | ctrl_r & 16'hA000}; // RULE_11
        FPEC_OFS_STATUS:  avs_readdata <= {30'h0, sts_r};
        FPEC_OFS_MASK:    avs_readdata <= {30'h0, mask_r};
        default:          avs_readdata <= '0; // RULE_01
      endcase
    end
  end
endmodule

/* rtl/fpec_pkg.sv */
// fpec_pkg: offsets, field positions, codes and timing for the flash control block
// assumes a 32-bit avalon-mm register port, word aligned
package fpec_pkg;
  // register byte addresses
  localparam logic [3:0] FPEC_OFS_CONTROL = 4'h0;
  localparam logic [3:0] FPEC_OFS_KEY     = 4'h4;
  localparam logic [3:0] FPEC_OFS_STATUS  = 4'h8;
  localparam logic [3:0] FPEC_OFS_MASK    = 4'hC;
  // control field positions
  localparam int FPEC_BIT_START = 15;
  localparam int FPEC_BIT_ALLOW = 14;
  localparam int FPEC_BIT_ERR   = 13;
  localparam int FPEC_BIT_ERASE = 6;
  localparam logic [15:0] FPEC_CTRL_WMASK = 16'h404F;
  localparam logic [15:0] FPEC_CTRL_RESET = 16'h0000;
  // unlock keys
  localparam logic [7:0] FPEC_KEY_FIRST  = 8'h55;
  localparam logic [7:0] FPEC_KEY_SECOND = 8'hAA;
  // operation codes
  localparam logic [3:0] FPEC_OP_ROW   = 4'h1;
  localparam logic [3:0] FPEC_OP_BLOCK = 4'h2;
  localparam logic [3:0] FPEC_OP_WORD  = 4'h3;
  localparam logic [3:0] FPEC_OP_BULK  = 4'hF;
  // geometry in instruction words
  localparam int FPEC_ROW_WORDS   = 64;
  localparam int FPEC_BLOCK_WORDS = 512;
  localparam int FPEC_ADDR_W      = 23;
  localparam int FPEC_DATA_W      = 24;
  // status bits: done, error
  localparam int FPEC_IRQ_DONE = 0;
  localparam int FPEC_IRQ_ERR  = 1;
  // step time per flash word in ns
  localparam int FPEC_CLK_NS     = 50;
  localparam int FPEC_STEP_NS    = 100;
  localparam int FPEC_STEP_CYC   = (FPEC_STEP_NS + FPEC_CLK_NS - 1) / FPEC_CLK_NS;
  typedef enum logic [1:0] {
    FPEC_IDLE  = 2'b00,
    FPEC_RUN   = 2'b01,
    FPEC_DONE  = 2'b11
  } fpec_state_t;
endpackage

/* rtl/fpec_latch_mem.sv */
// fpec_latch_mem: one-row holding latch memory for table writes
// assumes one write port from table writes and a registered read port
`timescale 1ns/1ns
module fpec_latch_mem #(
  parameter int WORDS = 64,
  parameter int DW    = 24
) (
  // clock
  input  wire logic                     clk,
  // write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(WORDS)-1:0] wr_addr,
  input  wire logic [DW-1:0]            wr_data,
  // read side
  input  wire logic [$clog2(WORDS)-1:0] rd_addr,
  output logic      [DW-1:0]            rd_data
);
  logic [DW-1:0] mem [WORDS];

  // no reset: latch contents are unknown at power-up, software fills them
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

/* tb/fpec_top_assertions.sv */
// fpec_top_assertions: port checks for fpec_top
// assumes a bind onto fpec_top, one clock, async active-low reset
`timescale 1ns/1ns
module fpec_top_assertions
  import fpec_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq,
  // stall and flash
  input wire logic        cpu_stall,
  input wire logic        fl_prog,
  input wire logic        fl_erase
);
  import fpec_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic rd_take;
  assign rd_take = avs_read && !avs_waitrequest;
  property p_stall_wait; cpu_stall && (avs_read || avs_write) |-> avs_waitrequest; endproperty
  a_stall_wait: assert property (p_stall_wait) else $error("bus taken during stall");
  property p_idle_nowait; !cpu_stall && avs_write |-> !avs_waitrequest; endproperty
  a_idle_nowait: assert property (p_idle_nowait) else $error("write wait while idle");
  property p_rd_one_wait; avs_read && avs_waitrequest && !cpu_stall |=> !avs_waitrequest; endproperty
  a_rd_one_wait: assert property (p_rd_one_wait) else $error("read wait too long");
  property p_flash_in_op; fl_prog || fl_erase |-> cpu_stall; endproperty
  a_flash_in_op: assert property (p_flash_in_op) else $error("flash step outside op");
  property p_one_kind; !(fl_prog && fl_erase); endproperty
  a_one_kind: assert property (p_one_kind) else $error("program and erase together");
  property p_ctrl_zeros;
    rd_take && avs_address == FPEC_OFS_CONTROL |->
      avs_readdata[12:7] == 6'h00 && avs_readdata[5:4] == 2'h0 && avs_readdata[31:16] == 16'h0;
  endproperty
  a_ctrl_zeros: assert property (p_ctrl_zeros) else $error("unused bits nonzero");
  property p_key_zero; rd_take && avs_address == FPEC_OFS_KEY |-> avs_readdata == 32'h0; endproperty
  a_key_zero: assert property (p_key_zero) else $error("key readable");
  property p_start_cause;
    $rose(cpu_stall) |-> $past(avs_write && avs_address == FPEC_OFS_CONTROL && avs_writedata[15]);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("stall without start");
  property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_stall_min; $rose(cpu_stall) |-> cpu_stall [*3]; endproperty
  a_stall_min: assert property (p_stall_min) else $error("operation too short");
  c_start: cover property ($rose(cpu_stall));
  c_erase: cover property (fl_erase);
  c_irq: cover property ($rose(irq));
endmodule

/* tb/fpec_flash_model.sv */
// fpec_flash_model: flash array stand-in, counts steps, can stretch busy
// assumes the flash port of fpec_top on the same clock
`timescale 1ns/1ns
module fpec_flash_model
  import fpec_pkg::*;
(
  // clock, reset, pacing
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   slow,
  // flash port
  input  wire logic                   fl_prog,
  input  wire logic                   fl_erase,
  input  wire logic [FPEC_ADDR_W-1:0] fl_addr,
  input  wire logic [FPEC_DATA_W-1:0] fl_wdata,
  output logic                        fl_busy,
  // observation
  output int                          n_prog,
  output int                          n_erase,
  output logic [FPEC_DATA_W-1:0]      wsum,
  output logic [FPEC_ADDR_W-1:0]      erase_lo
);
  import fpec_pkg::*;
  int hold;
  // slow mode holds each step 3 cycles, as a worn array would
  assign fl_busy = (hold != 0);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold <= 0;
      n_prog <= 0;
      n_erase <= 0;
      wsum <= '0;
      erase_lo <= '1;
    end else begin
      hold <= (slow && (fl_prog || fl_erase)) ? 3 : (hold > 0 ? hold - 1 : 0);
      if (fl_prog) begin
        n_prog <= n_prog + 1;
        wsum <= wsum ^ fl_wdata;
      end
      if (fl_erase) begin
        n_erase <= n_erase + 1;
        erase_lo <= (fl_addr < erase_lo) ? fl_addr : erase_lo;
      end
    end
  end
endmodule

/* tb/fpec_top_test.sv */
// fpec_top_test: register-level tests of fpec_top
// assumes fpec_flash_model on the flash port and the checker bound below
`timescale 1ns/1ns
module fpec_top_test;
  import fpec_pkg::*;
  localparam int RW = 8;
  localparam int BW = 16;
  localparam logic [15:0] EOFS = 16'(2 * (3 * BW + 5));
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, irq, cpu_stall, fl_prog, fl_erase, fl_busy;
  logic        tbl_wr = 1'b0;
  logic        serial_prog_mode = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] tbl_offset = 16'h0;
  logic [23:0] tbl_data = 24'h0;
  logic [23:0] fl_wdata, wsum, exp_sum;
  logic [22:0] fl_addr, erase_lo;
  logic [15:0] bad_cfg [5] = '{16'h4041, 16'h4002, 16'h404F, 16'h4005, 16'h0001};
  int          n_prog, n_erase, p0, e0;
  int          num_errors = 0;
  int          total_checks = 0;
  always #25 clk = ~clk;
  fpec_top #(.ROW_WORDS(RW), .BLOCK_WORDS(BW)) u_dut (.clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .irq,
    .tbl_wr, .table_page_reg(8'h00), .tbl_offset, .tbl_data, .serial_prog_mode, .cpu_stall,
    .fl_prog, .fl_erase, .fl_addr, .fl_wdata, .fl_busy);
  fpec_flash_model u_flash (.clk, .reset_n, .slow, .fl_prog, .fl_erase, .fl_addr, .fl_wdata,
    .fl_busy, .n_prog, .n_erase, .wsum, .erase_lo);
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // request stands until waitrequest is sampled low at a rising edge, data taken there
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 2000);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b1, a, 32'h0);
  endtask
  task automatic ld(input logic [15:0] ofs, input logic [23:0] d);
    @(posedge clk);
    tbl_wr <= 1'b1;
    tbl_offset <= ofs;
    tbl_data <= d;
    @(posedge clk);
    tbl_wr <= 1'b0;
  endtask
  task automatic go(input logic [15:0] cfg);
    int n;
    wr(FPEC_OFS_CONTROL, {16'h0, cfg});
    wr(FPEC_OFS_KEY, {24'h0, FPEC_KEY_FIRST});
    wr(FPEC_OFS_KEY, {24'h0, FPEC_KEY_SECOND});
    wr(FPEC_OFS_CONTROL, {16'h0, cfg | 16'h8000});
    repeat (2) @(posedge clk);
    @(negedge clk);
    n = 0;
    while (cpu_stall && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (cpu_stall) begin
      num_errors++;
      print_verdict();
    end
  endtask
  initial begin
    exp_sum = 24'h0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(FPEC_OFS_CONTROL);
    chk("ctrl reset", 32'h0, q);
    rd(FPEC_OFS_KEY);
    chk("key read", 32'h0, q);
    wr(FPEC_OFS_CONTROL, 32'hFFFF);
    rd(FPEC_OFS_CONTROL);
    chk("ctrl unkeyed", 32'h604F, q);
    rd(FPEC_OFS_STATUS);
    chk("status err", 32'h2, q);
    wr(FPEC_OFS_STATUS, 32'h3);
    wr(FPEC_OFS_MASK, 32'h1);
    for (int i = 0; i < RW; i++) begin
      ld(16'(2 * i), 24'hA50000 ^ 24'(i * 7));
      exp_sum = exp_sum ^ 24'hA50000 ^ 24'(i * 7);
    end
    go(16'h4001);
    chk("row steps", RW, n_prog);
    chk("row data", {8'h0, exp_sum}, {8'h0, wsum});
    rd(FPEC_OFS_CONTROL);
    chk("ctrl row done", 32'h4001, q);
    chk("irq done", 32'h1, {31'h0, irq});
    wr(FPEC_OFS_STATUS, 32'h1);
    @(negedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr(FPEC_OFS_MASK, 32'h0);
    slow <= 1'b1;
    go(16'h4003);
    chk("word steps", RW + 1, n_prog);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(FPEC_OFS_STATUS);
    chk("status done", 32'h1, q);
    ld(EOFS, 24'h0);
    go(16'h4042);
    chk("erase base", 32'(3 * BW), {9'h0, erase_lo});
    chk("erase no prog", RW + 1, n_prog);
    for (int i = 0; i < 5; i++) begin
      p0 = n_prog;
      e0 = n_erase;
      go(bad_cfg[i]);
      chk("refused prog", p0, n_prog);
      chk("refused erase", e0, n_erase);
      rd(FPEC_OFS_CONTROL);
      chk("refused ctrl", {16'h0, bad_cfg[i] | 16'h2000}, q);
    end
    wr(FPEC_OFS_CONTROL, 32'h4003);
    wr(FPEC_OFS_KEY, {24'h0, FPEC_KEY_FIRST});
    wr(FPEC_OFS_MASK, 32'h0);
    wr(FPEC_OFS_KEY, {24'h0, FPEC_KEY_SECOND});
    wr(FPEC_OFS_CONTROL, 32'hC003);
    repeat (8) @(posedge clk);
    rd(FPEC_OFS_CONTROL);
    chk("broken unlock", 32'h6003, q);
    chk("broken unlock steps", p0, n_prog);
    serial_prog_mode <= 1'b1;
    repeat (3) @(posedge clk);
    e0 = n_erase;
    go(16'h404F);
    chk("bulk erase", 32'h1, {31'h0, n_erase > e0});
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(FPEC_OFS_CONTROL);
    chk("ctrl second reset", 32'h0, q);
    print_verdict();
  end
endmodule
bind fpec_top fpec_top_assertions u_chk (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .cpu_stall, .fl_prog, .fl_erase);
